// ==== src/atg_top.sv ====
`timescale 1ns/10ps
// Overview of operation
// - aux input times error insertion when assigned there and error source external.
// - aux input gates bursts when assigned there and burst sequencing uses an external source.
// - divided clock output, N from 4 to 512 in steps of 2.
// - one sync pulse per pattern period, 8-bit position steps.
// - dual lane merge uses 16-bit position steps.
// - short patterns are repeated up to at least 512 or 1024 bits.
// - mixed pattern sync once per full mixed period (row length x rows x blocks) at block and row index.
// - changeover trigger pulses aux output at each pattern change when aux output carries pattern sync.
// - burst timing copy starts a set delay after burst pattern start.
// - burst timing copy stays high for a set pulse width.
// - burst delay and width move in 8 or 16 bit steps.
// - aux output off means a quiet aux output.
// - gating output carries the sequence sync signal only when enabled.
// - clock output at full rate or half rate of the data.
// - full rate uses 1/1 up to 16 Gbit/s, 1/2 above; ceiling by extension.
// - half rate accepts 1/2 from 2.4 Gbit/s; quarter clock 25 to 32.1.
module atg_top
  import atg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        aux_in,
  input  wire logic        pat_change,
  input  wire logic        burst_start,
  output logic             err_trig,
  output logic             burst_gate,
  output logic             aux_q,
  output logic             gate_q,
  output logic             clk_out_q,
  output logic             pat_en
);
  // -----------------------------------------------------------------
  // register bus
  // -----------------------------------------------------------------
  atg_ctrl_s   ctrl_q;
  logic [9:0]  divn_q;
  logic [31:0] patlen_q, sync_q, blkrow_q, rowlen_q, rows_q;
  atg_win_s    bwin_q;
  logic [15:0] rate_q;
  logic [7:0]  awa_q, ara_q;
  logic        aw_hold_q, w_hold_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        rate_err, eff_ok_q;
  logic [31:0] eff_q;
  atg_aux_e    aux_sel_q;
  logic        psync_q;

  wire [7:0]  wa      = aw_hold_q ? awa_q : s_axi_awaddr;
  wire [31:0] wd      = w_hold_q ? wd_q : s_axi_wdata;
  wire [3:0]  ws      = w_hold_q ? ws_q : s_axi_wstrb;
  wire        aw_in   = aw_hold_q | s_axi_awvalid;
  wire        w_in    = w_hold_q | s_axi_wvalid;
  wire        do_wr   = aw_in & w_in & ~bvalid_q;
  wire        wa_ok   = (wa <= ADDR_RATE) && (wa[1:0] == 2'h0);
  wire        ra_ok   = (s_axi_araddr <= ADDR_STAT)
                     && (s_axi_araddr[1:0] == 2'h0);
  wire        do_rd   = s_axi_arvalid & ~rvalid_q;
  wire [31:0] bmask   = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire        wr_len  = do_wr && wa == ADDR_PATLEN;
  wire        wr_ctrl = do_wr && wa == ADDR_CTRL;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awa_q     <= 8'h00;
      wd_q      <= 32'h0;
      ws_q      <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !do_wr)
      begin
        aw_hold_q <= 1'b1;
        awa_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr)
      begin
        w_hold_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wa_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q   <= '0;
      divn_q   <= DIVN_RST;
      patlen_q <= MINLEN_1CH;
      sync_q   <= 32'h1;
      blkrow_q <= 32'h0;
      rowlen_q <= 32'h0;
      rows_q   <= 32'h0;
      bwin_q   <= '0;
      rate_q   <= RATE_FULL_MAX;
    end
    else if (do_wr)
    begin
      case (wa)
        ADDR_CTRL:   ctrl_q   <= merge(ctrl_q, wd, bmask);
        ADDR_DIVN:   divn_q   <= 10'(merge({22'h0, divn_q}, wd, bmask));
        ADDR_PATLEN: patlen_q <= merge(patlen_q, wd, bmask);
        ADDR_SYNC:   sync_q   <= merge(sync_q, wd, bmask);
        ADDR_BLKROW: blkrow_q <= merge(blkrow_q, wd, bmask);
        ADDR_ROWLEN: rowlen_q <= merge(rowlen_q, wd, bmask);
        ADDR_ROWS:   rows_q   <= merge(rows_q, wd, bmask);
        ADDR_BDLY:   bwin_q.delay <= merge(bwin_q.delay, wd, bmask);
        ADDR_BWID:   bwin_q.width <= merge(bwin_q.width, wd, bmask);
        ADDR_RATE:   rate_q <= 16'(merge({16'h0, rate_q}, wd, bmask));
        default:     ;
      endcase
    end
  end

  wire [31:0] stat_w = {28'h0, eff_ok_q, gate_q, aux_q, rate_err};
  wire [31:0] rd_mux =
      (s_axi_araddr == ADDR_CTRL)   ? ctrl_q            :
      (s_axi_araddr == ADDR_DIVN)   ? {22'h0, divn_q}   :
      (s_axi_araddr == ADDR_PATLEN) ? patlen_q          :
      (s_axi_araddr == ADDR_SYNC)   ? sync_q            :
      (s_axi_araddr == ADDR_BLKROW) ? blkrow_q          :
      (s_axi_araddr == ADDR_ROWLEN) ? rowlen_q          :
      (s_axi_araddr == ADDR_ROWS)   ? rows_q            :
      (s_axi_araddr == ADDR_BDLY)   ? bwin_q.delay      :
      (s_axi_araddr == ADDR_BWID)   ? bwin_q.width      :
      (s_axi_araddr == ADDR_RATE)   ? {16'h0, rate_q}   :
      (s_axi_araddr == ADDR_STAT)   ? stat_w            : 32'h0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end
    else if (do_rd)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= ra_ok ? rd_mux : 32'h0;
      rresp_q  <= ra_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // -----------------------------------------------------------------
  // aux input routing
  // -----------------------------------------------------------------
  wire err_ext   = ctrl_q.err_src == SRC_EXT_TRIG
                || ctrl_q.err_src == SRC_EXT_EN;
  wire burst_ext = ctrl_q.burst_src == SRC_EXT_TRIG
                || ctrl_q.burst_src == SRC_EXT_EN;
  assign err_trig   = ~ctrl_q.aux_in_burst & err_ext & aux_in;
  assign burst_gate = ctrl_q.aux_in_burst & ctrl_q.burst_seq
                    & burst_ext & aux_in;

  // -----------------------------------------------------------------
  // pattern clock and clock output
  // -----------------------------------------------------------------
  wire quad_band = ctrl_q.quarter_sel && rate_q >= RATE_QUAD_MIN;
  wire [8:0] in_div = quad_band                  ? DIV_4 :
                      ctrl_q.half_rate           ? DIV_2 :
                      (rate_q > RATE_FULL_MAX)   ? DIV_2 : DIV_1;
  wire [15:0] ceil_w = ctrl_q.speed_ext ? RATE_CEIL_EXT : RATE_CEIL_STD;
  assign rate_err = (rate_q > ceil_w)
                 || (ctrl_q.half_rate && rate_q < RATE_HALF_MIN)
                 || (quad_band && !ctrl_q.speed_ext);

  logic co_tick, n_tick;

  atg_div u_patdiv (
    .clk   (clk),
    .nrst  (nrst),
    .en    (1'b1),
    .ratio (in_div),
    .tick  (pat_en)
  );

  atg_div u_codiv (
    .clk   (clk),
    .nrst  (nrst),
    .en    (pat_en),
    .ratio (ctrl_q.half_rate ? DIV_2 : DIV_1),
    .tick  (co_tick)
  );

  atg_div u_ndiv (
    .clk   (clk),
    .nrst  (nrst),
    .en    (pat_en),
    .ratio (divn_q[9:1]),
    .tick  (n_tick)
  );

  logic nclk_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_out_q <= 1'b0;
      nclk_q    <= 1'b0;
    end
    else
    begin
      clk_out_q <= clk_out_q ^ co_tick;
      nclk_q    <= nclk_q ^ n_tick;
    end
  end

  // -----------------------------------------------------------------
  // pattern period and sync pulse
  // -----------------------------------------------------------------
  wire [31:0] step   = ctrl_q.dual_lane_merge ? STEP_2CH : STEP_1CH;
  wire [31:0] minlen = ctrl_q.dual_lane_merge ? MINLEN_2CH : MINLEN_1CH;
  // mixed period and position from block and row index
  wire [31:0] rows_n = {16'h0, rows_q[15:0]};
  wire [31:0] mix_per = 32'(rowlen_q * rows_n * {16'h0, rows_q[31:16]});
  wire [31:0] mix_pos = 32'(({16'h0, blkrow_q[15:0]} * rows_n
                        + {16'h0, blkrow_q[31:16]}) * rowlen_q);
  wire [31:0] period = ctrl_q.mixed ? mix_per : eff_q;
  wire [31:0] target = ctrl_q.mixed ? mix_pos : sync_q - 32'h1;
  logic [31:0] pos_q, bcnt_q;

  // repeat short pattern up to the minimum
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eff_q    <= MINLEN_1CH;
      eff_ok_q <= 1'b1;
    end
    else if (wr_len || wr_ctrl)
    begin
      eff_q    <= wr_len ? merge(patlen_q, wd, bmask) : patlen_q;
      eff_ok_q <= 1'b0;
    end
    else if (!eff_ok_q && patlen_q != 32'h0)
    begin
      if (eff_q < minlen)
        eff_q <= eff_q + patlen_q;
      else
        eff_ok_q <= 1'b1;
    end
  end

  wire pos_wrap = pos_q + step >= period;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pos_q <= 32'h0;
    else if (pat_en)
      pos_q <= pos_wrap ? 32'h0 : pos_q + step;
  end

  // one pulse when the position falls in this word
  wire sync_hit = pat_en && target >= pos_q && target < pos_q + step;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      psync_q <= 1'b0;
    else
      psync_q <= sync_hit;
  end

  // -----------------------------------------------------------------
  // burst timing and gating
  // -----------------------------------------------------------------
  // burst bit counter from burst pattern start
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bcnt_q <= 32'h0;
    else if (burst_start)
      bcnt_q <= 32'h0;
    else if (pat_en && bcnt_q <= ~step)
      bcnt_q <= bcnt_q + step;
  end

  logic bhit_q, rhit_q;
  atg_win u_bwin (
    .clk   (clk),
    .nrst  (nrst),
    .en    (pat_en | burst_start),
    .cnt   (burst_start ? 32'h0 : bcnt_q),
    .win   (bwin_q),
    .hit_q (bhit_q)
  );

  atg_win u_rwin (
    .clk   (clk),
    .nrst  (nrst),
    .en    (pat_en),
    .cnt   (pos_q),
    .win   (bwin_q),
    .hit_q (rhit_q)
  );

  wire gate_d = ctrl_q.gate_en & (ctrl_q.burst_seq ? bhit_q : rhit_q);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gate_q <= 1'b0;
    else
      gate_q <= gate_d;
  end

  // -----------------------------------------------------------------
  // aux output selector
  // -----------------------------------------------------------------
  // changeover trigger rides on pattern sync
  wire chg = ctrl_q.chg_trig_en & pat_change;
  logic aux_d;
  always_comb
  begin
    case (aux_sel_q)
      AUX_OFF:   aux_d = 1'b0;
      AUX_NCLK:  aux_d = nclk_q;
      AUX_PSYNC: aux_d = psync_q | chg;
      AUX_BURST: aux_d = ctrl_q.burst_seq & bhit_q;
      default:   aux_d = 1'b0;
    endcase
  end

  // selector updates on pattern clock only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_sel_q <= AUX_OFF;
      aux_q     <= 1'b0;
    end
    else
    begin
      if (pat_en)
        aux_sel_q <= atg_aux_e'(ctrl_q.aux_mode);
      aux_q <= aux_d;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_aux_off_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (aux_sel_q == AUX_OFF) ##1 (aux_sel_q == AUX_OFF) |-> !aux_q)
    else $error("aux output active while off");
  a_gate_off_idle: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl_q.gate_en |=> !gate_q)
    else $error("gating output active while disabled");
  a_sel_on_boundary: assert property (@(posedge clk) disable iff (!nrst)
    !pat_en |=> $stable(aux_sel_q))
    else $error("aux selector changed off pattern clock");
  a_nclk_on_tick: assert property (@(posedge clk) disable iff (!nrst)
    $changed(nclk_q) |-> $past(n_tick) && $past(pat_en))
    else $error("divided clock moved without tick");
  a_sync_single: assert property (@(posedge clk) disable iff (!nrst)
    psync_q && in_div != DIV_1 |=> !psync_q)
    else $error("sync pulse longer than one cycle");
  a_err_route: assert property (@(posedge clk) disable iff (!nrst)
    err_trig |-> aux_in && err_ext && !ctrl_q.aux_in_burst)
    else $error("error trigger without routed aux input");
  a_burst_gate: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_q.aux_in_burst && ctrl_q.burst_seq && burst_ext && aux_in)
      |-> burst_gate)
    else $error("burst gate missing");
  a_clk_out_rate: assert property (@(posedge clk) disable iff (!nrst)
    $changed(clk_out_q) |-> $past(co_tick))
    else $error("clock output toggled off its tick");
  a_eff_min_len: assert property (@(posedge clk) disable iff (!nrst)
    $rose(eff_ok_q) |-> eff_q >= minlen)
    else $error("effective pattern below minimum");
endmodule : atg_top

// ==== src/atg_pkg.sv ====
package atg_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DIVN   = 8'h04;
  localparam logic [7:0] ADDR_PATLEN = 8'h08;
  localparam logic [7:0] ADDR_SYNC   = 8'h0c;
  localparam logic [7:0] ADDR_BLKROW = 8'h10;
  localparam logic [7:0] ADDR_ROWLEN = 8'h14;
  localparam logic [7:0] ADDR_ROWS   = 8'h18;
  localparam logic [7:0] ADDR_BDLY   = 8'h1c;
  localparam logic [7:0] ADDR_BWID   = 8'h20;
  localparam logic [7:0] ADDR_RATE   = 8'h24;
  localparam logic [7:0] ADDR_STAT   = 8'h28;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [9:0] DIVN_RST    = 10'h004;

  // -----------------------------------------------------------------
  // pattern and rate figures
  // -----------------------------------------------------------------
  localparam logic [31:0] STEP_1CH   = 32'h0000_0008;
  localparam logic [31:0] STEP_2CH   = 32'h0000_0010;
  localparam logic [31:0] MINLEN_1CH = 32'h0000_0200;
  localparam logic [31:0] MINLEN_2CH = 32'h0000_0400;
  // rates in units of 100 Mbit/s
  localparam logic [15:0] RATE_FULL_MAX = 16'd160;
  localparam logic [15:0] RATE_HALF_MIN = 16'd24;
  localparam logic [15:0] RATE_QUAD_MIN = 16'd250;
  localparam logic [15:0] RATE_CEIL_EXT = 16'd321;
  localparam logic [15:0] RATE_CEIL_STD = 16'd210;
  localparam logic [8:0]  DIV_1 = 9'h001;
  localparam logic [8:0]  DIV_2 = 9'h002;
  localparam logic [8:0]  DIV_4 = 9'h004;

  typedef enum logic [1:0] {AUX_OFF, AUX_NCLK, AUX_PSYNC, AUX_BURST}
    atg_aux_e;
  typedef enum logic [1:0] {SRC_INT, SRC_EXT_TRIG, SRC_EXT_EN}
    atg_src_e;

  typedef struct packed {
    logic [16:0] rsvd;
    logic [1:0]  burst_src;
    logic [1:0]  err_src;
    logic        mixed;
    logic        speed_ext;
    logic        quarter_sel;
    logic        half_rate;
    logic        dual_lane_merge;
    logic        burst_seq;
    logic        gate_en;
    logic        chg_trig_en;
    logic        aux_in_burst;
    logic [1:0]  aux_mode;
  } atg_ctrl_s;

  typedef struct packed {
    logic [31:0] delay;
    logic [31:0] width;
  } atg_win_s;
endpackage : atg_pkg

// ==== src/atg_div.sv ====
`timescale 1ns/10ps
module atg_div
  import atg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       en,
  input  wire logic [8:0] ratio,
  output logic            tick
);
  logic [8:0] cnt_q;
  wire        last = (cnt_q >= ratio - 9'h001);

  assign tick = en & last;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 9'h000;
    else if (en)
      cnt_q <= last ? 9'h000 : cnt_q + 9'h001;
  end
endmodule : atg_div

// ==== src/atg_win.sv ====
`timescale 1ns/10ps
module atg_win
  import atg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        en,
  input  wire logic [31:0] cnt,
  input  wire atg_win_s    win,
  output logic             hit_q
);
  wire [32:0] stop = {1'b0, win.delay} + {1'b0, win.width};
  wire        in_w = ({1'b0, cnt} >= {1'b0, win.delay})
                   && ({1'b0, cnt} < stop);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hit_q <= 1'b0;
    else if (en)
      hit_q <= in_w;
  end

  a_win_start: assert property (@(posedge clk) disable iff (!nrst)
    (en && cnt == win.delay && win.width != 32'h0) |=> hit_q)
    else $error("window did not open at delay");
endmodule : atg_win

// ==== testbench/atg_far_model.sv ====
`timescale 1ns/10ps
module atg_far_model
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic gate_lvl,
  input  wire logic chg_req,
  input  wire logic burst_req,
  output logic      aux_in,
  output logic      pat_change,
  output logic      burst_start
);
  // --------------------
  // far-side equipment
  // --------------------
  // gate held stable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_in      <= 1'b0;
      pat_change  <= 1'b0;
      burst_start <= 1'b0;
    end
    else
    begin
      aux_in      <= gate_lvl;
      pat_change  <= chg_req;
      burst_start <= burst_req;
    end
  end
endmodule : atg_far_model

// ==== testbench/aux_timing_signal_gen_tb_top.sv ====
`timescale 1ns/10ps
module aux_timing_signal_gen_tb_top
  import atg_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, seen;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, err_trig, burst_gate;
  logic        aux_in, pat_change, burst_start, pat_en;
  logic        aux_q, gate_q, clk_out_q, gate_lvl, chg_req, burst_req;
  logic        sel_g, obs, lst;
  int          num_errors, total_checks, cyc, pe_cnt;
  int          w0, tg;
  logic [31:0] rc [5] = '{32'h0, 32'h800, 32'h1000, 32'h2024, 32'h4024};
  logic [4:0]  re = 5'b00110;
  logic [4:0]  rb = 5'b11000;
  logic [31:0] nv [3] = '{32'h4, 32'h6, 32'h200};
  logic [31:0] pl [4] = '{32'h64, 32'h400, 32'h400, 32'h12c};
  logic [31:0] pp [4] = '{32'h4b, 32'h80, 32'h40, 32'h4b};
  logic [3:0]  pm = 4'b1100;
  logic [31:0] rt [4] = '{32'ha0, 32'hdc, 32'ha0, 32'h12c};
  logic [31:0] rk [4] = '{32'h0, 32'h0, 32'h80, 32'h300};
  int          rw [4] = '{64, 32, 32, 16};
  int          rg [4] = '{64, 32, 16, 16};
  logic [3:0]  rs = 4'b0010;

  assign obs = sel_g ? gate_q : aux_q;
  always #4 clk = ~clk;

  atg_top dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .aux_in, .pat_change, .burst_start, .err_trig,
    .burst_gate, .aux_q, .gate_q, .clk_out_q, .pat_en);

  atg_far_model far (.clk, .nrst, .gate_lvl, .chg_req, .burst_req, .aux_in,
    .pat_change, .burst_start);

  // --------------------
  // cycle count and pattern word count
  // --------------------
  always @(posedge clk)
  begin
    pe_cnt <= pe_cnt + int'(pat_en);
    cyc    <= cyc + 1;
    if (cyc == 80000)
    begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end

  // --------------------
  // shared tasks
  // --------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  // pattern words from a rise of obs to the next rise or fall
  task automatic len(input logic rise2, input string nm,
                     input logic [31:0] e);
    int a;
    @(posedge obs);
    @(posedge obs);
    #1;
    a = pe_cnt;
    if (rise2)
      @(posedge obs);
    else
      @(negedge obs);
    #1;
    chk(nm, e, 32'(pe_cnt - a));
    @(posedge clk);
  endtask : len

  // --------------------
  // main sequence
  // --------------------
  initial
  begin
    // response channels are always ready
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h1;
    {s_axi_arvalid, s_axi_rready, gate_lvl, chg_req} = 4'h4;
    {burst_req, sel_g, seen} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {num_errors, total_checks, cyc, pe_cnt} = 128'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_DIVN, 32'h4, RESP_OKAY);
    rd(ADDR_PATLEN, 32'h200, RESP_OKAY);
    rd(ADDR_SYNC, 32'h1, RESP_OKAY);
    rd(ADDR_RATE, 32'ha0, RESP_OKAY);
    rd(8'h2c, 32'h0, RESP_SLVERR);
    wr(ADDR_STAT, 32'h1, RESP_SLVERR);
    wr(ADDR_DIVN, 32'h6, RESP_OKAY);
    rd(ADDR_DIVN, 32'h6, RESP_OKAY);
    foreach (rc[i])
    begin
      wr(ADDR_CTRL, rc[i], RESP_OKAY);
      for (int l = 0; l < 2; l++)
      begin
        gate_lvl <= l[0];
        repeat (2) @(posedge clk);
        chk("err_trig", {31'h0, re[i] & l[0]}, {31'h0, err_trig});
        chk("burst_gate", {31'h0, rb[i] & l[0]}, {31'h0, burst_gate});
      end
    end
    wr(ADDR_BDLY, 32'h10, RESP_OKAY);
    wr(ADDR_BWID, 32'h18, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    seen = 2'h0;
    repeat (300) @(posedge clk) seen = seen | {aux_q, gate_q};
    chk("aux_off", 32'h0, {31'h0, seen[1]});
    chk("gate_off", 32'h0, {31'h0, seen[0]});
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    foreach (nv[i])
    begin
      wr(ADDR_DIVN, nv[i], RESP_OKAY);
      len(1'b1, "nclk_period", nv[i]);
    end
    foreach (pl[i])
    begin
      wr(ADDR_CTRL, {25'h0, pm[i], 6'h2}, RESP_OKAY);
      wr(ADDR_PATLEN, pl[i], RESP_OKAY);
      len(1'b1, "sync_period", pp[i]);
    end
    // mixed: 64 bit rows, 2 rows, 2 blocks, 32 words
    wr(ADDR_ROWLEN, 32'h40, RESP_OKAY);
    wr(ADDR_ROWS, 32'h0002_0002, RESP_OKAY);
    wr(ADDR_BLKROW, 32'h0001_0001, RESP_OKAY);
    wr(ADDR_CTRL, 32'h402, RESP_OKAY);
    len(1'b1, "mixed_period", 32'h20);
    wr(ADDR_PATLEN, 32'h10000, RESP_OKAY);
    for (int t = 0; t < 2; t++)
    begin
      wr(ADDR_CTRL, {28'h0, t[0], 3'h2}, RESP_OKAY);
      chg_req <= 1'b1;
      @(posedge clk);
      chg_req <= 1'b0;
      seen = 2'h0;
      repeat (8) @(posedge clk) seen[0] = seen[0] | aux_q;
      chk("chg_trig", {31'h0, t[0]}, {31'h0, seen[0]});
    end
    wr(ADDR_PATLEN, 32'h200, RESP_OKAY);
    wr(ADDR_CTRL, 32'h23, RESP_OKAY);
    fork
      len(1'b0, "burst_width", 32'h3);
      repeat (3)
      begin
        burst_req <= 1'b1;
        @(posedge clk);
        burst_req <= 1'b0;
        @(posedge clk);
        #1;
        w0 = pe_cnt;
        @(posedge obs);
        #1;
        // 16 bit delay is two words, plus window and output registers
        chk("burst_delay", 32'h4, 32'(pe_cnt - w0));
        repeat (400) @(posedge clk);
      end
    join
    wr(ADDR_CTRL, 32'h10, RESP_OKAY);
    sel_g = 1'b1;
    len(1'b0, "gate_width", 32'h3);
    // pattern word cadence and clock output edges per band
    foreach (rt[i])
    begin
      wr(ADDR_RATE, rt[i], RESP_OKAY);
      wr(ADDR_CTRL, rk[i], RESP_OKAY);
      repeat (4) @(posedge clk);
      w0 = pe_cnt;
      tg = 0;
      lst = clk_out_q;
      repeat (64)
      begin
        @(posedge clk);
        tg = tg + int'(clk_out_q != lst);
        lst = clk_out_q;
      end
      chk("pat_words", 32'(rw[i]), 32'(pe_cnt - w0));
      chk("clk_out_edges", 32'(rg[i]), 32'(tg));
      rd(ADDR_STAT, {28'h0, 3'h4, rs[i]}, RESP_OKAY);
    end
    end_of_test;
  end
endmodule : aux_timing_signal_gen_tb_top
